// file: rtl/bit_sync.sv
// Purpose: Two-flop synchroniser for levels and event toggles
// Assumes: Each bit is independent, or quasi-static while in use
// Notes:   First stage is seen only by the second stage
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    // ============================================================
    // Two stages, constant reset value
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_r <= RST;
            q_o    <= RST;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule // bit_sync

`default_nettype wire

// file: rtl/i2c_bus_condition_detect.sv
// Purpose: Start/Stop/Restart detection, collision on start, 10-bit prior match
// Assumes: LINK_CLK_I runs free and samples both bus lines
// Notes:   Own address and mode levels must be changed only while idle
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Data fall with clock high is Start
// - Start moves bus from idle to active
// - Data already low at issue is collision
// - Data rise with clock high is Stop
// - Stop needs one clock-low period first
// - Restart accepted wherever Stop would be
// - Restart resets slave logic like Start
// - Prior-matched read address holds clock low
// - Full 10-bit write match sets prior flag
// - Stop, high write or mismatch clears prior
// - Enables add Start/Stop interrupts in quiet modes
// - Enables ignored in natively interrupting modes
// - Start sets start-seen and maybe interrupt
// - High write match sets address-update flag
module i2c_bus_condition_detect (
    // Clocks and reset
    input  wire logic       CORE_CLK_I,
    input  wire logic       LINK_CLK_I,
    input  wire logic       ARST_N_I,
    // Bus lines
    input  wire logic       SDA_I,
    input  wire logic       SCL_I,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    output logic            SCL_O,
    output logic            SCL_OE_O,
    // Control
    input  wire logic       START_REQ_I,
    input  wire logic       CLK_RELEASE_I,
    input  wire logic       ADDR10_EN_I,
    input  wire logic [9:0] OWN_ADDR_I,
    input  wire logic       NATIVE_IRQ_MODE_I,
    input  wire logic       START_IRQ_EN_I,
    input  wire logic       STOP_IRQ_EN_I,
    input  wire logic       IRQ_CLR_I,
    input  wire logic       UA_CLR_I,
    input  wire logic       COLL_CLR_I,
    // Status
    output logic            START_SEEN_O,
    output logic            STOP_SEEN_O,
    output logic            IRQ_FLAG_O,
    output logic            ADDR_UPDATE_O,
    output logic            COLLISION_O,
    output logic            PRIOR_MATCH_O,
    output logic            CLK_HELD_O,
    output logic            BUS_ACTIVE_O
);

    // One bit wide so that no state code is left unused
    typedef enum logic {M_IDLE, M_DRIVE} mstate_t;

    logic [1:0]                          pin_s;
    logic                                sda_s, scl_s, sda_d_r, scl_d_r;
    logic [2:0]                          ctl_s;
    logic [9:0]                          own_s;
    logic                                req_d_r, rel_d_r;
    logic                                start_det, stop_det, scl_rise, scl_fall;
    logic                                req_edge, rel_edge, byte_done, hi_ok;
    logic [7:0]                          byte_val, shreg_r;
    logic [3:0]                          bit_cnt_r;
    i2c_cond_pkg::byte_phase_t           byte_idx_r;
    logic                                scl_low_seen_r, bus_active_r, prior_r;
    logic                                hold_pend_r, scl_hold_r, sda_drv_r;
    logic                                start_tgl_r, stop_tgl_r, ua_tgl_r, coll_tgl_r;
    mstate_t                             m_state_r;
    logic [i2c_cond_pkg::HOLD_CNT_W-1:0] hold_cnt_r;
    logic                                req_tgl_r, rel_tgl_r;
    i2c_cond_pkg::link_status_t          lnk, lnk_s;
    logic                                start_prev_r, stop_prev_r, ua_prev_r, coll_prev_r;
    logic                                start_evt, stop_evt, ua_evt, coll_evt;

    // ============================================================
    // Link side: pin and control synchronisers
    bit_sync #(.W(2), .RST(i2c_cond_pkg::PIN_IDLE)) u_pin_sync (
        .clk_i    (LINK_CLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      ({SDA_I, SCL_I}),
        .q_o      (pin_s)
    );
    bit_sync #(.W(3), .RST(3'h0)) u_ctl_sync (
        .clk_i    (LINK_CLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      ({req_tgl_r, rel_tgl_r, ADDR10_EN_I}),
        .q_o      (ctl_s)
    );
    // Quasi-static: changed only while the bus is idle
    bit_sync #(.W(10), .RST(10'h000)) u_own_sync (
        .clk_i    (LINK_CLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      (OWN_ADDR_I),
        .q_o      (own_s)
    );

    assign sda_s = pin_s[1];
    assign scl_s = pin_s[0];

    // Previous samples for edge detection
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            sda_d_r <= 1'b1;
            scl_d_r <= 1'b1;
            req_d_r <= 1'b0;
            rel_d_r <= 1'b0;
        end
        else
        begin
            sda_d_r <= sda_s;
            scl_d_r <= scl_s;
            req_d_r <= ctl_s[2];
            rel_d_r <= ctl_s[1];
        end
    end

    // ============================================================
    // Condition decode
    assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s && scl_low_seen_r;
    assign scl_rise  = scl_s && !scl_d_r;
    assign scl_fall  = !scl_s && scl_d_r;
    assign req_edge  = ctl_s[2] ^ req_d_r;
    assign rel_edge  = ctl_s[1] ^ rel_d_r;
    assign byte_done = scl_rise && bus_active_r && (bit_cnt_r == i2c_cond_pkg::LAST_BIT_IDX);
    assign byte_val  = {shreg_r[6:0], sda_s};
    assign hi_ok     = (byte_val[7:3] == i2c_cond_pkg::HI_ADDR_PREFIX)
                       && (byte_val[2:1] == own_s[9:8]);

    // Bus state; a clock-low period arms Stop only, Restart needs none
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            scl_low_seen_r <= 1'b0;
            bus_active_r   <= 1'b0;
        end
        else
        begin
            if (start_det)
                scl_low_seen_r <= 1'b0;
            else if (!scl_s)
                scl_low_seen_r <= 1'b1;
            if (start_det)
                bus_active_r <= 1'b1;
            else if (stop_det)
                bus_active_r <= 1'b0;
        end
    end

    // ============================================================
    // Bit counter; Start and Restart both rewind to a new address
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            bit_cnt_r <= 4'h0;
            shreg_r   <= 8'h00;
        end
        else if (start_det)
        begin
            bit_cnt_r <= 4'h0;
            shreg_r   <= 8'h00;
        end
        else if (scl_rise && bus_active_r)
        begin
            shreg_r   <= byte_val;
            bit_cnt_r <= (bit_cnt_r == i2c_cond_pkg::ACK_BIT_IDX) ? 4'h0 : bit_cnt_r + 4'h1;
        end
    end

    // 10-bit addressing phase and prior-match flag
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            byte_idx_r <= i2c_cond_pkg::BYTE_HI;
            prior_r    <= 1'b0;
        end
        else if (stop_det)
            prior_r <= 1'b0;
        else if (start_det)
            byte_idx_r <= i2c_cond_pkg::BYTE_HI;
        else if (byte_done && ctl_s[0])
        begin
            byte_idx_r <= i2c_cond_pkg::BYTE_DATA;
            if (byte_idx_r == i2c_cond_pkg::BYTE_HI)
            begin
                if (!hi_ok || !byte_val[0])
                    prior_r <= 1'b0;
                if (hi_ok && !byte_val[0])
                    byte_idx_r <= i2c_cond_pkg::BYTE_LO;
            end
            else if (byte_idx_r == i2c_cond_pkg::BYTE_LO && byte_val == own_s[7:0])
                prior_r <= 1'b1;
        end
    end

    // Address-update event: high write match, and every low byte
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            ua_tgl_r <= 1'b0;
        else if (byte_done && ctl_s[0] && !start_det && !stop_det
                 && ((byte_idx_r == i2c_cond_pkg::BYTE_HI && hi_ok && !byte_val[0])
                     || byte_idx_r == i2c_cond_pkg::BYTE_LO))
            ua_tgl_r <= !ua_tgl_r;
    end

    // ============================================================
    // Master start issue, with collision check before driving
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            m_state_r  <= M_IDLE;
            hold_cnt_r <= '0;
            sda_drv_r  <= 1'b0;
            coll_tgl_r <= 1'b0;
        end
        else
        begin
            unique case (m_state_r)
                M_IDLE:
                begin
                    if (req_edge && (!sda_s || !scl_s))
                        coll_tgl_r <= !coll_tgl_r;
                    else if (req_edge)
                    begin
                        sda_drv_r  <= 1'b1;
                        hold_cnt_r <= '0;
                        m_state_r  <= M_DRIVE;
                    end
                end
                M_DRIVE:
                begin
                    hold_cnt_r <= hold_cnt_r + 1'b1;
                    if (hold_cnt_r == i2c_cond_pkg::HOLD_CNT_W'(i2c_cond_pkg::START_HOLD_CYC - 1))
                    begin
                        sda_drv_r <= 1'b0;               // Clock goes low in this same cycle
                        m_state_r <= M_IDLE;
                    end
                end
            endcase
        end
    end

    // Clock hold: after our start, or a prior-matched read request;
    // the read hold is applied at the fall after the acknowledge so no pulse is cut short, the start hold as its hold time ends
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            hold_pend_r <= 1'b0;
            scl_hold_r  <= 1'b0;
        end
        else
        begin
            if (byte_done && ctl_s[0] && byte_idx_r == i2c_cond_pkg::BYTE_HI
                && hi_ok && byte_val[0] && prior_r)
                hold_pend_r <= 1'b1;
            else if (start_det || stop_det || (scl_fall && bit_cnt_r == 4'h0))
                hold_pend_r <= 1'b0;
            if (m_state_r == M_DRIVE
                && hold_cnt_r == i2c_cond_pkg::HOLD_CNT_W'(i2c_cond_pkg::START_HOLD_CYC - 1))
                scl_hold_r <= 1'b1;
            else if (hold_pend_r && scl_fall && bit_cnt_r == 4'h0)
                scl_hold_r <= 1'b1;
            else if (rel_edge)
                scl_hold_r <= 1'b0;
        end
    end

    // Start and Stop event toggles toward the core
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            start_tgl_r <= 1'b0;
            stop_tgl_r  <= 1'b0;
        end
        else
        begin
            if (start_det)
                start_tgl_r <= !start_tgl_r;
            if (stop_det)
                stop_tgl_r <= !stop_tgl_r;
        end
    end

    // Pin drivers; open drain, only ever low
    always_ff @(posedge LINK_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            SDA_O    <= 1'b0;
            SCL_O    <= 1'b0;
            SDA_OE_O <= 1'b0;
            SCL_OE_O <= 1'b0;
        end
        else
        begin
            SDA_O    <= 1'b0;
            SCL_O    <= 1'b0;
            SDA_OE_O <= sda_drv_r;
            SCL_OE_O <= scl_hold_r;
        end
    end

    // ============================================================
    // Core side: request toggles and returning status
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            req_tgl_r <= 1'b0;
            rel_tgl_r <= 1'b0;
        end
        else
        begin
            req_tgl_r <= req_tgl_r ^ START_REQ_I;
            rel_tgl_r <= rel_tgl_r ^ CLK_RELEASE_I;
        end
    end

    assign lnk = '{start_tgl: start_tgl_r, stop_tgl: stop_tgl_r, ua_tgl: ua_tgl_r,
                   coll_tgl: coll_tgl_r, prior: prior_r, hold: scl_hold_r,
                   active: bus_active_r};

    bit_sync #(.W(i2c_cond_pkg::LINK_STATUS_W), .RST(7'h00)) u_stat_sync (
        .clk_i    (CORE_CLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      (lnk),
        .q_o      (lnk_s)
    );

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            start_prev_r <= 1'b0;
            stop_prev_r  <= 1'b0;
            ua_prev_r    <= 1'b0;
            coll_prev_r  <= 1'b0;
        end
        else
        begin
            start_prev_r <= lnk_s.start_tgl;
            stop_prev_r  <= lnk_s.stop_tgl;
            ua_prev_r    <= lnk_s.ua_tgl;
            coll_prev_r  <= lnk_s.coll_tgl;
        end
    end

    assign start_evt = lnk_s.start_tgl ^ start_prev_r;
    assign stop_evt  = lnk_s.stop_tgl ^ stop_prev_r;
    assign ua_evt    = lnk_s.ua_tgl ^ ua_prev_r;
    assign coll_evt  = lnk_s.coll_tgl ^ coll_prev_r;

    // Seen bits stand until the opposing condition
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            START_SEEN_O <= 1'b0;
            STOP_SEEN_O  <= 1'b0;
        end
        else if (start_evt)
        begin
            START_SEEN_O <= 1'b1;
            STOP_SEEN_O  <= 1'b0;
        end
        else if (stop_evt)
        begin
            START_SEEN_O <= 1'b0;
            STOP_SEEN_O  <= 1'b1;
        end
    end

    // Sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            IRQ_FLAG_O    <= 1'b0;
            ADDR_UPDATE_O <= 1'b0;
            COLLISION_O   <= 1'b0;
        end
        else
        begin
            if ((start_evt && (NATIVE_IRQ_MODE_I || START_IRQ_EN_I))
                || (stop_evt && (NATIVE_IRQ_MODE_I || STOP_IRQ_EN_I)))
                IRQ_FLAG_O <= 1'b1;
            else if (IRQ_CLR_I)
                IRQ_FLAG_O <= 1'b0;
            if (ua_evt)
                ADDR_UPDATE_O <= 1'b1;
            else if (UA_CLR_I)
                ADDR_UPDATE_O <= 1'b0;
            if (coll_evt)
                COLLISION_O <= 1'b1;
            else if (COLL_CLR_I)
                COLLISION_O <= 1'b0;
        end
    end

    // Level status
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            PRIOR_MATCH_O <= 1'b0;
            CLK_HELD_O    <= 1'b0;
            BUS_ACTIVE_O  <= 1'b0;
        end
        else
        begin
            PRIOR_MATCH_O <= lnk_s.prior;
            CLK_HELD_O    <= lnk_s.hold;
            BUS_ACTIVE_O  <= lnk_s.active;
        end
    end

    // ============================================================
    // Assertions
    sequence s_req_busy;
        req_edge && m_state_r == M_IDLE && (!sda_s || !scl_s);
    endsequence
    sequence s_hi_read_prior;
        byte_done && ctl_s[0] && byte_idx_r == i2c_cond_pkg::BYTE_HI
        && hi_ok && byte_val[0] && prior_r && !stop_det;
    endsequence

    AST_START_ACTIVE: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        start_det |=> bus_active_r && !scl_low_seen_r)
        else $error("start did not activate bus");
    AST_START_TGL: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        start_det |=> start_tgl_r != $past(start_tgl_r))
        else $error("start event lost");
    AST_STOP_IDLE: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        stop_det |=> !bus_active_r && !prior_r && stop_tgl_r != $past(stop_tgl_r))
        else $error("stop did not idle bus");
    AST_NO_EARLY_STOP: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        start_det ##1 scl_s[*2] |-> stop_tgl_r == $past(stop_tgl_r, 2))
        else $error("stop taken without clock low");
    AST_RESTART_RESET: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        (start_det && bus_active_r) |=> bit_cnt_r == 4'h0
                                        && byte_idx_r == i2c_cond_pkg::BYTE_HI)
        else $error("restart did not rewind");
    AST_COLLISION: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        s_req_busy |=> coll_tgl_r != $past(coll_tgl_r) && !sda_drv_r)
        else $error("collision not reported");
    AST_PRIOR_SET: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        (byte_done && ctl_s[0] && byte_idx_r == i2c_cond_pkg::BYTE_LO
         && byte_val == own_s[7:0] && !stop_det && !start_det) |=> prior_r)
        else $error("prior match not set");
    AST_HOLD_PEND: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
        s_hi_read_prior |=> hold_pend_r && prior_r)
        else $error("read after prior match not held");
    AST_IRQ: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        (start_evt && (NATIVE_IRQ_MODE_I || START_IRQ_EN_I)) |=> IRQ_FLAG_O)
        else $error("start interrupt missing");
    AST_SEEN: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        start_evt |=> START_SEEN_O && !STOP_SEEN_O ##1 (START_SEEN_O || $past(stop_evt)))
        else $error("start-seen not standing");

endmodule // i2c_bus_condition_detect

`default_nettype wire

// file: rtl/i2c_cond_pkg.sv
// Purpose: Shared constants and carriers for the bus-condition block
// Assumes: 40 MHz core clock, free-running link sampling clock of 80 ns
// Notes:   All offsets and counts, and all codes but the master states, live here; nothing is imported
package i2c_cond_pkg;

    // ============================================================
    // Timing
    localparam int CORE_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 80;
    // Least hold of the data line low before the clock line follows
    localparam int START_HOLD_NS  = 4000;
    localparam int START_HOLD_CYC =
        (START_HOLD_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int HOLD_CNT_W     = 8;

    // ============================================================
    // Address format
    localparam logic [4:0] HI_ADDR_PREFIX = 5'h1E;
    localparam int         BYTE_BITS      = 8;
    localparam logic [3:0] LAST_BIT_IDX   = 4'h7;
    localparam logic [3:0] ACK_BIT_IDX    = 4'h8;
    localparam logic [1:0] PIN_IDLE       = 2'h3;

    // ============================================================
    // Types
    typedef enum logic [1:0] {BYTE_HI, BYTE_LO, BYTE_DATA} byte_phase_t;

    // Event toggles and levels sent from the link side to the core side
    typedef struct packed {
        logic start_tgl;
        logic stop_tgl;
        logic ua_tgl;
        logic coll_tgl;
        logic prior;
        logic hold;
        logic active;
    } link_status_t;

    localparam int LINK_STATUS_W = 7;

endpackage

// file: sim/bus_master_model.sv
// Purpose: Behavioural bus master on the two bus lines
// Assumes: Open-drain lines with pull-ups, resolved by the bench
// Notes:   Clock stands high between frames
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
    // Link clock and resolved clock line
    input  wire logic clk_i,
    input  wire logic scl_line_i,
    // Driven levels, 1 = released
    output logic      sda_o,
    output logic      scl_o
);
    // Clock releases that ran out of their bound
    int stalls = 0;
    // ==========================================
    // Idle bus at time zero
    initial
    begin
        sda_o = 1'b1;
        scl_o = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Release clock; a slave may stretch it
    task automatic clk_up();
        scl_o <= 1'b1;
        for (int k = 0; k < 400 && scl_line_i !== 1'b1; k++) @(posedge clk_i);
        if (scl_line_i !== 1'b1)
            stalls++;
        step(4);
    endtask
    // Start or Restart from either clock level
    task automatic start_cond();
        sda_o <= 1'b1;
        step(4);
        clk_up();
        sda_o <= 1'b0;
        step(4);
        scl_o <= 1'b0;
        step(4);
    endtask
    // Stop always follows a clock-low time
    task automatic stop_cond();
        scl_o <= 1'b0;
        step(2);
        sda_o <= 1'b0;
        step(2);
        clk_up();
        sda_o <= 1'b1;
        step(4);
    endtask
    // Data dip and return with clock high throughout
    task automatic glitch();
        sda_o <= 1'b0;
        step(4);
        sda_o <= 1'b1;
        step(4);
    endtask
    task automatic pull_low();
        sda_o <= 1'b0;
        step(4);
    endtask
    // Eight bits MSB first, then a released ack bit
    task automatic send_byte(input logic [7:0] b);
        logic [8:0] f;
        f = {b, 1'b1};
        for (int i = 8; i >= 0; i--)
        begin
            sda_o <= f[i];
            step(2);
            clk_up();
            scl_o <= 1'b0;
            step(2);
        end
    endtask
endmodule // bus_master_model
`default_nettype wire

// file: sim/i2c_bus_condition_detect_bench.sv
// Purpose: Self-checking bench for the bus-condition block
// Assumes: 40 MHz core clock, 80 ns link clock
// Notes:   Status waits use the handed-over crossing latency
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_condition_detect_bench;
    // ==========================================
    // Clocks, reset and stimulus
    logic       core_clk = 1'b0;
    logic       link_clk = 1'b1;
    logic       arst_n   = 1'b0;
    logic [4:0] pls      = 5'h00;
    logic       a10 = 1'b0, nat = 1'b0, sie = 1'b0, pie = 1'b0;
    logic [9:0] own      = 10'h000;
    logic       m_sda, m_scl, sda_out, sda_oe, scl_out, scl_oe;
    logic       seen_s, seen_p, irq, ua, coll, prior, held, active;
    logic       sda_w, scl_w;
    int         mismatches = 0;
    int         tests_run  = 0;
    localparam logic [9:0] ADR  = 10'h2A5;
    localparam logic [7:0] HI_W = {i2c_cond_pkg::HI_ADDR_PREFIX, ADR[9:8], 1'b0};
    always #12.5 core_clk = ~core_clk;
    always #40 link_clk = ~link_clk;
    // Wired-AND of master and our open-drain drivers
    assign sda_w = m_sda & ~(sda_oe & ~sda_out);
    assign scl_w = m_scl & ~(scl_oe & ~scl_out);
    bus_master_model bm (.clk_i(link_clk), .scl_line_i(scl_w), .sda_o(m_sda), .scl_o(m_scl));
    i2c_bus_condition_detect uut (
        .CORE_CLK_I(core_clk), .LINK_CLK_I(link_clk), .ARST_N_I(arst_n),
        .SDA_I(sda_w), .SCL_I(scl_w), .SDA_O(sda_out), .SDA_OE_O(sda_oe),
        .SCL_O(scl_out), .SCL_OE_O(scl_oe), .START_REQ_I(pls[0]),
        .CLK_RELEASE_I(pls[1]), .ADDR10_EN_I(a10), .OWN_ADDR_I(own),
        .NATIVE_IRQ_MODE_I(nat), .START_IRQ_EN_I(sie), .STOP_IRQ_EN_I(pie),
        .IRQ_CLR_I(pls[2]), .UA_CLR_I(pls[3]), .COLL_CLR_I(pls[4]),
        .START_SEEN_O(seen_s), .STOP_SEEN_O(seen_p), .IRQ_FLAG_O(irq),
        .ADDR_UPDATE_O(ua), .COLLISION_O(coll), .PRIOR_MATCH_O(prior),
        .CLK_HELD_O(held), .BUS_ACTIVE_O(active));
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One-cycle pulse; status crossings then settle
    task automatic pulse(input int b);
        @(posedge core_clk);
        pls <= 5'h01 << b;
        @(posedge core_clk);
        pls <= 5'h00;
        cyc(24);
    endtask
    task automatic check(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_detect();
        check(|{seen_s, seen_p, irq, ua, coll, prior, held, active}, 1'b0, "reset");
        @(posedge core_clk);
        sie <= 1'b1;
        bm.glitch();
        cyc(24);
        check(seen_s, 1'b1, "start");
        check(seen_p, 1'b0, "stop without clock low");
        check(active, 1'b1, "active");
        check(irq, 1'b1, "start irq");
        pulse(2);
        bm.stop_cond();
        cyc(24);
        check(seen_p, 1'b1, "stop");
        check(seen_s, 1'b0, "start cleared");
        check(irq, 1'b0, "stop irq off");
        sie <= 1'b0;
        pie <= 1'b1;
        bm.start_cond();
        bm.stop_cond();
        cyc(24);
        check(irq, 1'b1, "stop irq");
        check(active, 1'b0, "idle");
        pulse(2);
        $display("t_detect done");
    endtask
    task automatic t_issue();
        bm.pull_low();
        pulse(0);
        check(coll, 1'b1, "collision");
        check(sda_oe, 1'b0, "no drive");
        pulse(4);
        check(coll, 1'b0, "collision clear");
        bm.stop_cond();
        pulse(0);
        check(sda_oe, 1'b1, "own start");
        cyc(180);
        check(scl_oe, 1'b1, "clock held");
        pulse(1);
        check(scl_oe, 1'b0, "released");
        bm.stop_cond();
        $display("t_issue done");
    endtask
    task automatic t_ten();
        @(posedge core_clk);
        {a10, nat, pie, own} <= {3'h6, ADR};
        pulse(2);
        bm.start_cond();
        cyc(24);
        check(irq, 1'b1, "native irq");
        bm.send_byte(HI_W);
        cyc(24);
        check(ua, 1'b1, "update flag");
        pulse(3);
        bm.send_byte(ADR[7:0]);
        cyc(24);
        check(prior, 1'b1, "prior set");
        bm.start_cond();
        cyc(24);
        check(prior, 1'b1, "prior kept");
        bm.send_byte(HI_W | 8'h01);
        cyc(24);
        check(held, 1'b1, "read hold");
        check(scl_oe, 1'b1, "clock low");
        pulse(1);
        check(held, 1'b0, "hold released");
        bm.stop_cond();
        cyc(24);
        check(prior, 1'b0, "prior cleared");
        bm.start_cond();
        bm.send_byte(HI_W);
        bm.send_byte(ADR[7:0]);
        cyc(24);
        check(prior, 1'b1, "prior set again");
        bm.start_cond();
        bm.send_byte(HI_W);
        cyc(24);
        check(prior, 1'b0, "high write clears prior");
        bm.stop_cond();
        $display("t_ten done");
    endtask
    // Watchdog against a hang
    initial
    begin
        #1ms;
        mismatches++;
        give_verdict();
    end
    initial
    begin
        cyc(12);
        arst_n <= 1'b1;
        cyc(8);
        t_detect();
        t_issue();
        t_ten();
        check(bm.stalls == 0, 1'b1, "clock release bound");
        give_verdict();
    end
endmodule // i2c_bus_condition_detect_bench
`default_nettype wire
